// ==== rtl/color_compare.sv ====
// Colour compare of four plane bytes against per-plane compare bits.
// Planes whose include bit is zero never block a match.
`timescale 1ns/1ps
module color_compare
    import gfx_dp_pkg::*;
(
    input wire plane_bytes_t planes_i,
    input wire logic [3:0] color_i,
    input wire logic [3:0] include_i,
    output logic [7:0] match_o
);

    wire [NUM_PLANES-1:0][7:0] plane_ok;

    genvar p;
    generate
        for (p = 0; p < NUM_PLANES; p = p + 1) begin : g_plane
            // An excluded plane reports a match in every bit position.
            assign plane_ok[p] = ~(planes_i[p] ^ {8{color_i[p]}}) | {8{~include_i[p]}};
        end
    endgenerate

    assign match_o = plane_ok[0] & plane_ok[1] & plane_ok[2] & plane_ok[3];

endmodule // color_compare

// ==== rtl/gfx_dp_pkg.sv ====
// Constants, field positions and carrier types for the graphics data path register bank.
// Assumes one clock for the I/O port, the host memory path and the frame buffer planes.
//
// Contract
// - Host writes an index to the index port, then uses the data port.
// - The index port reads zero after reset.
// - Index bits 3-0 select registers 0 to 8; bits 7-4 are reserved.
// - Write mode 0: a fill-enabled plane gets its fill bit in all eight bits.
// - Write mode 3: rotated data AND bit mask is the mask; fill bits give color.
// - A plane without fill enable takes the normal host data path result.
// - Fill enable bits matter only in write mode 0.
// - Read mode 1 compares each included plane bit with its compare color bit.
// - Read mode 1 returns 1 where every included plane matches.
// - Function field: 00 pass, 01 AND, 10 OR, 11 XOR with the latch.
// - Host write data is rotated right by the three-bit rotate count.
// - Read mode 0 returns the plane named by the read plane field.
// - Odd/even ignores read plane bit 0; chained mode ignores both bits.
// - The read plane field also picks the latch shown on latch readback.
// - Read mode is mode bit 3; write mode is mode bits 1-0.
// - Write mode 1 writes each plane with its read latch.
// - Read latches hold an unaltered copy of the last frame buffer read.
// - Read mode 0 returns the addressed byte of the chosen plane.
package gfx_dp_pkg;

    localparam logic [15:0] IO_INDEX_ADDR = 16'h03ce;
    localparam logic [15:0] IO_DATA_ADDR = 16'h03cf;

    localparam int NUM_PLANES = 4;
    localparam int NUM_REGS = 9;
    localparam logic [3:0] LAST_INDEX = 4'h8;
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [7:0] REG_RESET = 8'h00;

    localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
    localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
    localparam logic [3:0] IDX_COMPARE_COLOR = 4'h2;
    localparam logic [3:0] IDX_ROTATE_AND_FUNCTION = 4'h3;
    localparam logic [3:0] IDX_READ_PLANE_CHOICE = 4'h4;
    localparam logic [3:0] IDX_GRAPHICS_MODE_CONTROL = 4'h5;
    localparam logic [3:0] IDX_MISCELLANEOUS_CONTROL = 4'h6;
    localparam logic [3:0] IDX_COMPARE_PLANE_INCLUDE = 4'h7;
    localparam logic [3:0] IDX_WRITE_BIT_MASK = 4'h8;

    // Writable bits per index, index 8 first; everything else reads back zero.
    localparam logic [8:0][7:0] REG_WMASK = {8'hff, 8'h0f, 8'hff, 8'h7b, 8'h03, 8'h1f, 8'h0f, 8'h0f, 8'h0f};

    localparam int ROT_LSB = 0;
    localparam int ROT_MSB = 2;
    localparam int FUNC_LSB = 3;
    localparam int FUNC_MSB = 4;
    localparam int READ_PLANE_LSB = 0;
    localparam int READ_PLANE_MSB = 1;
    localparam int WMODE_LSB = 0;
    localparam int WMODE_MSB = 1;
    localparam int RMODE_BIT = 3;

    localparam logic [1:0] FUNC_PASS = 2'h0;
    localparam logic [1:0] FUNC_AND = 2'h1;
    localparam logic [1:0] FUNC_OR = 2'h2;
    localparam logic [1:0] FUNC_XOR = 2'h3;

    localparam logic [1:0] WMODE_0 = 2'h0;
    localparam logic [1:0] WMODE_1 = 2'h1;
    localparam logic [1:0] WMODE_2 = 2'h2;
    localparam logic [1:0] WMODE_3 = 2'h3;

    localparam logic [7:0] ALL_BITS = 8'hff;

    typedef logic [NUM_PLANES-1:0][7:0] plane_bytes_t;

    typedef struct packed {
        logic we;
        plane_bytes_t data;
        logic [7:0] mask;
    } fb_write_t;

endpackage

// ==== rtl/plane_combine.sv ====
// One plane's logical combine of write data with that plane's read latch.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module plane_combine
    import gfx_dp_pkg::*;
(
    input wire logic [1:0] func_i,
    input wire logic [7:0] src_i,
    input wire logic [7:0] latch_i,
    output logic [7:0] result_o
);

    wire [7:0] and_val = src_i & latch_i;
    wire [7:0] or_val = src_i | latch_i;
    wire [7:0] xor_val = src_i ^ latch_i;

    assign result_o = (func_i == FUNC_AND) ? and_val :
                      (func_i == FUNC_OR) ? or_val :
                      (func_i == FUNC_XOR) ? xor_val : src_i;

endmodule // plane_combine

// ==== rtl/vga_graphics_datapath_regs.sv ====
// Indexed graphics register bank and the per-plane host data path of a four-plane frame buffer.
// Assumes the I/O port, host memory strobes and frame buffer run on core_clk_i and that the
// sequencer supplies the odd/even and chained addressing levels on the same clock.
`timescale 1ns/1ps
module vga_graphics_datapath_regs
    import gfx_dp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic [1:0] mem_addr_lo_i,
    input wire logic fb_rvalid_i,
    input wire plane_bytes_t fb_rdata_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_rvalid_o,
    output logic fb_we_o,
    output plane_bytes_t fb_wdata_o,
    output logic [7:0] fb_wmask_o,
    input wire logic odd_even_i,
    input wire logic chain4_i,
    output logic [7:0] latch_readback_o,
    output logic [7:0] miscellaneous_control_o,
    output logic [7:0] graphics_mode_control_o
);

    // Index port and indexed register storage.
    logic [3:0] graphics_index_port;
    // Each entry has its own flip-flops below; this array is only a read view of them.
    wire [7:0] regs [0:NUM_REGS-1];

    // Memory read latches, one byte per plane.
    plane_bytes_t read_latch;

    // I/O decode.
    wire index_sel = (io_addr_i == IO_INDEX_ADDR);
    wire data_sel = (io_addr_i == IO_DATA_ADDR);
    wire index_in_range = (graphics_index_port <= LAST_INDEX);
    wire index_write = io_wr_i & index_sel;
    wire data_write = io_wr_i & data_sel & index_in_range;

    // Named views of the register fields.
    wire [7:0] fill_value = regs[IDX_FILL_VALUE];
    wire [7:0] fill_enable = regs[IDX_FILL_ENABLE];
    wire [7:0] compare_color = regs[IDX_COMPARE_COLOR];
    wire [7:0] rotate_and_function = regs[IDX_ROTATE_AND_FUNCTION];
    wire [7:0] read_plane_choice = regs[IDX_READ_PLANE_CHOICE];
    wire [7:0] graphics_mode_control = regs[IDX_GRAPHICS_MODE_CONTROL];
    wire [7:0] miscellaneous_control = regs[IDX_MISCELLANEOUS_CONTROL];
    wire [7:0] compare_plane_include = regs[IDX_COMPARE_PLANE_INCLUDE];
    wire [7:0] write_bit_mask = regs[IDX_WRITE_BIT_MASK];

    wire [2:0] rotate_count = rotate_and_function[ROT_MSB:ROT_LSB];
    wire [1:0] combine_func = rotate_and_function[FUNC_MSB:FUNC_LSB];
    wire [1:0] plane_field = read_plane_choice[READ_PLANE_MSB:READ_PLANE_LSB];
    wire [1:0] write_mode = graphics_mode_control[WMODE_MSB:WMODE_LSB];
    wire read_mode = graphics_mode_control[RMODE_BIT];

    // Register readback through the two ports.
    wire [7:0] index_readback = {4'h0, graphics_index_port};
    wire [7:0] data_readback = index_in_range ? regs[graphics_index_port] : 8'h00;
    wire [7:0] next_io_rdata = index_sel ? index_readback :
                               data_sel ? data_readback : 8'h00;

    // Index port: only the low four bits are kept; reserved bits stay zero.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            graphics_index_port <= INDEX_RESET;
        end else if (index_write) begin
            graphics_index_port <= io_wdata_i[3:0];
        end
    end

    // Indexed registers, one entry per index.
    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r = r + 1) begin : g_reg
            wire hit = data_write & (graphics_index_port == 4'(r));
            logic [7:0] entry;
            always_ff @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    entry <= REG_RESET;
                end else if (hit) begin
                    entry <= io_wdata_i & REG_WMASK[r];
                end
            end
            assign regs[r] = entry;
        end
    endgenerate

    // Register read answer, one cycle after the strobe.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            if (io_rd_i) begin
                io_rdata_o <= next_io_rdata;
            end
        end
    end

    // Host write data path.
    // The byte is doubled so that a right shift brings the low bits around to the top.
    wire [15:0] doubled = {mem_wdata_i, mem_wdata_i} >> rotate_count;
    wire [7:0] rotated = doubled[7:0];

    plane_bytes_t write_source;
    plane_bytes_t combined;
    plane_bytes_t next_fb_wdata;

    genvar p;
    generate
        for (p = 0; p < NUM_PLANES; p = p + 1) begin : g_plane
            wire [7:0] fill_byte = {8{fill_value[p]}};
            wire fill_here = fill_enable[p] & (write_mode == WMODE_0);
            wire [7:0] mode0_src = fill_here ? fill_byte : rotated;
            // Mode 2 spreads host data bit p across the plane byte.
            wire [7:0] mode2_src = {8{mem_wdata_i[p]}};

            assign write_source[p] = (write_mode == WMODE_3) ? fill_byte :
                                     (write_mode == WMODE_2) ? mode2_src : mode0_src;

            plane_combine u_combine (
                .func_i(combine_func),
                .src_i(write_source[p]),
                .latch_i(read_latch[p]),
                .result_o(combined[p])
            );

            assign next_fb_wdata[p] = (write_mode == WMODE_1) ? read_latch[p] : combined[p];
        end
    endgenerate

    // Mode 1 copies latches whole; mode 3 derives its mask from the rotated host byte.
    wire [7:0] mode3_mask = rotated & write_bit_mask;
    wire [7:0] next_fb_wmask = (write_mode == WMODE_1) ? ALL_BITS :
                               (write_mode == WMODE_3) ? mode3_mask : write_bit_mask;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fb_we_o <= 1'b0;
            fb_wdata_o <= '0;
            fb_wmask_o <= 8'h00;
        end else begin
            fb_we_o <= mem_wr_i;
            if (mem_wr_i) begin
                fb_wdata_o <= next_fb_wdata;
                fb_wmask_o <= next_fb_wmask;
            end
        end
    end

    // Host read data path.
    // Chained addressing lets the address pick the plane; odd/even lets address bit 0 pick the plane's low bit.
    wire [1:0] chosen_plane = chain4_i ? mem_addr_lo_i :
                              odd_even_i ? {plane_field[1], mem_addr_lo_i[0]} : plane_field;
    wire [7:0] mode0_read = fb_rdata_i[chosen_plane];
    wire [7:0] mode1_read;

    color_compare u_compare (
        .planes_i(fb_rdata_i),
        .color_i(compare_color[3:0]),
        .include_i(compare_plane_include[3:0]),
        .match_o(mode1_read)
    );

    wire [7:0] next_mem_rdata = read_mode ? mode1_read : mode0_read;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            read_latch <= '0;
            mem_rdata_o <= 8'h00;
            mem_rvalid_o <= 1'b0;
        end else begin
            mem_rvalid_o <= fb_rvalid_i;
            if (fb_rvalid_i) begin
                read_latch <= fb_rdata_i;
                mem_rdata_o <= next_mem_rdata;
            end
        end
    end

    // Latch readback follows the plane field without the addressing overrides, since it
    // is a register read, not a frame buffer access.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_readback_o <= 8'h00;
            miscellaneous_control_o <= 8'h00;
            graphics_mode_control_o <= 8'h00;
        end else begin
            latch_readback_o <= read_latch[plane_field];
            miscellaneous_control_o <= miscellaneous_control;
            graphics_mode_control_o <= graphics_mode_control;
        end
    end

endmodule // vga_graphics_datapath_regs

// ==== tb/fb_plane_model.sv ====
// Behavioural frame buffer holding one four-plane location.
// Assumes the bank's write outputs and a read request from the bench on the same clock.
`timescale 1ns/1ps
module fb_plane_model
    import gfx_dp_pkg::*;
#(
    parameter plane_bytes_t INIT = 32'h00000000
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic rd_req_i,
    input wire logic fb_we_i,
    input wire plane_bytes_t fb_wdata_i,
    input wire logic [7:0] fb_wmask_i,
    output logic fb_rvalid_o,
    output plane_bytes_t fb_rdata_o
);
    plane_bytes_t cells;
    // Outside a read the data lines flip each cycle, so stale data never passes for a fresh read.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cells <= INIT;
            fb_rvalid_o <= 1'b0;
            fb_rdata_o <= '0;
        end else begin
            fb_rvalid_o <= rd_req_i;
            fb_rdata_o <= rd_req_i ? cells : ~fb_rdata_o;
            for (int p = 0; p < NUM_PLANES; p++) begin
                if (fb_we_i) cells[p] <= (cells[p] & ~fb_wmask_i) | (fb_wdata_i[p] & fb_wmask_i);
            end
        end
    end
endmodule // fb_plane_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the graphics data path register bank and a frame buffer model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb_top;
    import gfx_dp_pkg::*;
    typedef struct packed {
        logic [7:0] fv, fe, rf, gm, bm, wd;
        logic [31:0] ed;
        logic [7:0] em;
    } row_t;
    localparam plane_bytes_t LATCH_INIT = 32'hf00faa55;
    row_t rows [8] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h3c, 32'h3c3c3c3c, 8'hff},
        '{8'h05, 8'h03, 8'h01, 8'h00, 8'h0f, 8'h01, 32'h808000ff, 8'h0f},
        '{8'h00, 8'h00, 8'h08, 8'h00, 8'hff, 8'hff, 32'hf00faa55, 8'hff},
        '{8'h00, 8'h00, 8'h10, 8'h00, 8'hff, 8'h0f, 32'hff0faf5f, 8'hff},
        '{8'h00, 8'h00, 8'h18, 8'h00, 8'hff, 8'hff, 32'h0ff055aa, 8'hff},
        '{8'h0a, 8'h0f, 8'h02, 8'h03, 8'h0f, 8'hf0, 32'hff00ff00, 8'h0c},
        '{8'h00, 8'h0f, 8'h00, 8'h01, 8'h0f, 8'h12, 32'hf00faa55, 8'hff},
        '{8'h00, 8'h0f, 8'h00, 8'h02, 8'hff, 8'h05, 32'h00ff00ff, 8'hff}};
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic mem_wr_i = 1'b0;
    logic rd_req = 1'b0;
    logic odd_even_i = 1'b0;
    logic chain4_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000;
    logic [7:0] io_wdata_i = 8'h00;
    logic [7:0] mem_wdata_i = 8'h00;
    logic [1:0] mem_addr_lo_i = 2'h0;
    logic fb_rvalid_i, io_rvalid_o, mem_rvalid_o, fb_we_o;
    plane_bytes_t fb_rdata_i, fb_wdata_o;
    logic [7:0] io_rdata_o, mem_rdata_o, fb_wmask_o, latch_readback_o;
    logic [7:0] miscellaneous_control_o, graphics_mode_control_o;
    int n_mismatch = 0;
    int cmp_count = 0;

    vga_graphics_datapath_regs DUT (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o),
        .io_rvalid_o(io_rvalid_o),
        .mem_wr_i(mem_wr_i),
        .mem_wdata_i(mem_wdata_i),
        .mem_addr_lo_i(mem_addr_lo_i),
        .fb_rvalid_i(fb_rvalid_i),
        .fb_rdata_i(fb_rdata_i),
        .mem_rdata_o(mem_rdata_o),
        .mem_rvalid_o(mem_rvalid_o),
        .fb_we_o(fb_we_o),
        .fb_wdata_o(fb_wdata_o),
        .fb_wmask_o(fb_wmask_o),
        .odd_even_i(odd_even_i),
        .chain4_i(chain4_i),
        .latch_readback_o(latch_readback_o),
        .miscellaneous_control_o(miscellaneous_control_o),
        .graphics_mode_control_o(graphics_mode_control_o)
    );
    fb_plane_model #(.INIT(LATCH_INIT)) u_fb (.core_clk_i(core_clk_i), .rst_i(rst_i), .rd_req_i(rd_req),
        .fb_we_i(fb_we_o), .fb_wdata_i(fb_wdata_o), .fb_wmask_i(fb_wmask_o), .fb_rvalid_o(fb_rvalid_i),
        .fb_rdata_o(fb_rdata_i));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i) #1;
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(posedge core_clk_i) #1;
        io_wr_i = 1'b0;
    endtask

    task automatic greg(input logic [7:0] idx, input logic [7:0] d);
        io_wr(IO_INDEX_ADDR, idx);
        io_wr(IO_DATA_ADDR, d);
    endtask

    task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk_i) #1;
        io_addr_i = a;
        io_rd_i = 1'b1;
        @(posedge core_clk_i) #1;
        io_rd_i = 1'b0;
        check({io_rvalid_o, io_rdata_o}, {1'b1, exp});
    endtask

    task automatic mem_write(input logic [7:0] d);
        @(posedge core_clk_i) #1;
        mem_wdata_i = d;
        mem_wr_i = 1'b1;
        @(posedge core_clk_i) #1;
        mem_wr_i = 1'b0;
        check(fb_we_o, 1'b1);
    endtask

    task automatic fb_rd(input logic [7:0] exp);
        @(posedge core_clk_i) #1;
        rd_req = 1'b1;
        @(posedge core_clk_i) #1;
        rd_req = 1'b0;
        for (int i = 0; i < 4 && mem_rvalid_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        if (mem_rvalid_o !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
        check(mem_rdata_o, exp);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        fb_rd(LATCH_INIT[0]);
        foreach (rows[i]) begin
            greg(8'h00, rows[i].fv);
            greg(8'h01, rows[i].fe);
            greg(8'h03, rows[i].rf);
            greg(8'h05, rows[i].gm);
            greg(8'h08, rows[i].bm);
            mem_write(rows[i].wd);
            check(fb_wdata_o, rows[i].ed);
            check(fb_wmask_o, rows[i].em);
        end
        // A second reset restores the model's cells, so the reads below know the stored bytes.
        rst_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        io_rd(IO_INDEX_ADDR, 8'h00);
        greg(8'hf5, 8'hff);
        io_rd(IO_INDEX_ADDR, 8'h05);
        io_rd(IO_DATA_ADDR, 8'h7b);
        check(graphics_mode_control_o, 8'h7b);
        greg(8'h06, 8'ha5);
        io_rd(IO_DATA_ADDR, 8'ha5);
        check(miscellaneous_control_o, 8'ha5);
        greg(8'h09, 8'hff);
        io_rd(IO_DATA_ADDR, 8'h00);
        greg(8'h05, 8'h01);
        fb_rd(LATCH_INIT[0]);
        mem_write(8'h00);
        check(fb_wdata_o, LATCH_INIT);
        greg(8'h05, 8'h00);
        for (int p = 0; p < 4; p++) begin
            greg(8'h04, 8'(p));
            fb_rd(LATCH_INIT[p]);
            @(posedge core_clk_i) #1;
            check(latch_readback_o, LATCH_INIT[p]);
        end
        odd_even_i = 1'b1;
        fb_rd(LATCH_INIT[2]);
        chain4_i = 1'b1;
        // The address picks plane 1 while the plane field still names plane 3.
        mem_addr_lo_i = 2'h1;
        fb_rd(LATCH_INIT[1]);
        chain4_i = 1'b0;
        odd_even_i = 1'b0;
        greg(8'h02, 8'h01);
        greg(8'h07, 8'h07);
        greg(8'h05, 8'h08);
        fb_rd(8'h50);
        greg(8'h07, 8'h01);
        fb_rd(8'h55);
        print_verdict();
    end
endmodule // tb_top

// ==== tb/vga_graphics_datapath_regs_assertions.sv ====
// Port-level checker for the graphics data path register bank.
// Assumes one clock and an active-high asynchronous reset; bound after the module.
`timescale 1ns/1ps
module gdp_checker
    import gfx_dp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic mem_wr_i,
    input wire logic [1:0] mem_addr_lo_i,
    input wire logic fb_rvalid_i,
    input wire plane_bytes_t fb_rdata_i,
    input wire logic [7:0] mem_rdata_o,
    input wire logic mem_rvalid_o,
    input wire logic fb_we_o,
    input wire plane_bytes_t fb_wdata_o,
    input wire logic [7:0] fb_wmask_o,
    input wire logic chain4_i,
    input wire logic [7:0] graphics_mode_control_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] sel_byte = fb_rdata_i[mem_addr_lo_i];
    // A mode change is only trusted two edges after the last port write, since the copy lags.
    AST_IO_ANSWER: assert property (io_rd_i |=> io_rvalid_o) else $error("io read not answered");
    AST_IO_QUIET: assert property (!io_rd_i |=> !io_rvalid_o) else $error("io answer without read");
    AST_INDEX_RSV: assert property ((io_rd_i && io_addr_i == IO_INDEX_ADDR) |=> io_rdata_o[7:4] == 4'h0)
        else $error("index upper bits not zero");
    AST_MODE_RSV: assert property (graphics_mode_control_o[7] == 1'b0 && graphics_mode_control_o[2] == 1'b0)
        else $error("mode reserved bits set");
    AST_WR_ANSWER: assert property (mem_wr_i |=> fb_we_o) else $error("write not passed on");
    AST_WR_QUIET: assert property (!mem_wr_i |=> !fb_we_o) else $error("write strobe without cause");
    AST_RD_ANSWER: assert property (fb_rvalid_i |=> mem_rvalid_o) else $error("read not returned");
    AST_CHAIN_READ: assert property ((fb_rvalid_i && chain4_i && !graphics_mode_control_o[RMODE_BIT]
        && !$past(io_wr_i)) |=> mem_rdata_o == $past(sel_byte)) else $error("chained read wrong plane");
    AST_LATCH_WRITE: assert property ((fb_rvalid_i ##1 !fb_rvalid_i ##1 (mem_wr_i && !$past(io_wr_i)
        && graphics_mode_control_o[1:0] == WMODE_1)) |=> fb_wdata_o == $past(fb_rdata_i, 3)
        && fb_wmask_o == ALL_BITS) else $error("latch write wrong");
    cover property (mem_wr_i && graphics_mode_control_o[1:0] == WMODE_3);
    cover property (fb_rvalid_i && graphics_mode_control_o[RMODE_BIT]);
    cover property (io_rd_i && io_addr_i == IO_DATA_ADDR);
endmodule // gdp_checker

bind vga_graphics_datapath_regs gdp_checker u_chk (.core_clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_rdata_o, .io_rvalid_o, .mem_wr_i, .mem_addr_lo_i, .fb_rvalid_i, .fb_rdata_i, .mem_rdata_o,
    .mem_rvalid_o, .fb_we_o, .fb_wdata_o, .fb_wmask_o, .chain4_i, .graphics_mode_control_o);
